// ==== rbm_arb.sv ====
`timescale 1ns/1ps
module rbm_arb (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Requests and grants
   input wire logic [1:0] req_i,
   input wire logic enable_i,
   output logic [1:0] grant_o
);

   logic last_reg;

   // Round robin so neither unit starves the shared memory
   always_comb begin
      grant_o = 2'h0;
      if (enable_i) begin
         if (req_i[0] && (!req_i[1] || last_reg)) begin
            grant_o = 2'h1;
         end else if (req_i[1]) begin
            grant_o = 2'h2;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         last_reg <= 1'b1;
      end else if (grant_o[0]) begin
         last_reg <= 1'b0;
      end else if (grant_o[1]) begin
         last_reg <= 1'b1;
      end
   end

endmodule // rbm_arb

// ==== rbm_mem_model.sv ====
`timescale 1ns/1ps
module rbm_mem_model (
   // Device side
   input wire logic [26:0] addr_i,
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic [2:0] drv_i,
   input wire logic [2:0] dev_i,
   // Board side
   input wire logic [2:0] strap_i,
   output logic [2:0] pin_o,
   output logic [15:0] data_o
);
   assign pin_o = (drv_i & dev_i) | (~drv_i & strap_i);
   // Released bus shows the inverse so a stale match cannot pass
   assign data_o = (!cs_n_i && !oe_n_i) ? (addr_i[15:0] ^ 16'hA5C3) : ~(addr_i[15:0] ^ 16'hA5C3);
endmodule // rbm_mem_model

// ==== rbm_pkg.sv ====
package rbm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int STATIC_ACCESS_NS = 600;
   localparam int STATIC_CYC = (STATIC_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROW_PHASE_NS = 200;
   localparam int ROW_CYC = (ROW_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_PHASE_NS = 400;
   localparam int COL_CYC = (COL_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_STEP_NS = 200;
   localparam int INIT_STEP_CYC = (INIT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_STEPS = 10;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and field positions
   localparam int ADDR_W = 28;
   localparam int DATA_W = 16;
   localparam int PIN_W = 27;
   localparam int MUX_W = 12;
   localparam int PAGE_BIT = 27;
   localparam int ROW_LSB = 12;
   localparam int MUX_PIN9 = 18;
   localparam int MUX_PIN10 = 20;
   localparam int MUX_PIN11 = 22;
   localparam int CNT_W = 4;
   localparam int WCNT_W = 9;

   ////////////////////////////////////////////////////////////////////////////
   // Boot values
   localparam logic [WCNT_W-1:0] BOOT_WORDS = 9'h100;
   localparam logic [15:0] VEC_ROM = 16'h0100;
   localparam logic [15:0] VEC_BOOT = 16'h0000;
   localparam logic [ADDR_W-1:0] BOOT_BASE = 28'h0000100;
   localparam logic [1:0] PROC_INDEX = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      MT_ROM = 2'h0,
      MT_SRAM = 2'h1,
      MT_DRAM = 2'h2,
      MT_SDRAM = 2'h3
   } rbm_mtype_t;

   typedef struct packed {
      logic boot;
      logic ras;
      logic cas;
   } rbm_strap_t;

   typedef struct packed {
      rbm_mtype_t low;
      rbm_mtype_t high;
   } rbm_page_cfg_t;

   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } rbm_req_t;

   typedef enum logic [6:0] {
      M_HOLD = 7'h01,
      M_INIT = 7'h02,
      M_IDLE = 7'h04,
      M_STATIC = 7'h08,
      M_ROW = 7'h10,
      M_COL = 7'h20,
      M_OFF = 7'h40
   } rbm_state_t;

endpackage

// ==== rbm_top.sv ====
`timescale 1ns/1ps
module rbm_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Power and configuration
   input wire logic power_down_pin_n_i,
   input wire rbm_pkg::rbm_mtype_t fw_high_type_i,
   input wire logic [1:0] synth_start_i,
   // Control processor memory ports
   input wire logic [1:0] cp_req_valid_i,
   input wire rbm_pkg::rbm_req_t [1:0] cp_req_i,
   output logic [1:0] cp_ack_o,
   output logic [rbm_pkg::DATA_W-1:0] cp_rdata_o,
   // Burst transfer ports
   input wire logic [1:0] burst_valid_i,
   input wire logic [1:0][rbm_pkg::DATA_W-1:0] burst_data_i,
   output logic [1:0] burst_ready_o,
   // Processor status
   output logic [1:0] control_processor_run_o,
   output logic [1:0][15:0] control_processor_start_o,
   output logic [1:0] processor_index_bit_o,
   output logic [1:0] synth_idle_o,
   output rbm_pkg::rbm_page_cfg_t page_cfg_o,
   output logic sdram_init_busy_o,
   output logic osc_enable_o,
   output logic pll_enable_o,
   // Memory pins
   output logic [rbm_pkg::PIN_W-1:0] memory_address_pins_o,
   output logic low_page_chip_select_n_o,
   output logic high_page_chip_select_n_o,
   output logic mem_we_n_o,
   output logic mem_oe_n_o,
   output logic mem_ctrl_oe_o,
   output logic [rbm_pkg::DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_o,
   input wire logic [rbm_pkg::DATA_W-1:0] mem_data_i,
   // Strap pins doubling as strobes
   input wire logic ras_pin_n_i,
   output logic ras_pin_n_o,
   output logic ras_pin_oe_o,
   input wire logic cas_pin_n_i,
   output logic cas_pin_n_o,
   output logic cas_pin_oe_o,
   input wire logic refresh_pin_n_i,
   output logic refresh_pin_n_o,
   output logic refresh_pin_oe_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [rbm_pkg::PIN_W-1:0] mux_pins(input logic [rbm_pkg::MUX_W-1:0] m);
      logic [rbm_pkg::PIN_W-1:0] p;
      p = '0;
      p[8:0] = m[8:0];
      p[rbm_pkg::MUX_PIN9] = m[9];
      p[rbm_pkg::MUX_PIN10] = m[10];
      p[rbm_pkg::MUX_PIN11] = m[11];
      return p;
   endfunction

   function automatic rbm_pkg::rbm_mtype_t strobe_type(input logic ras, input logic cas,
                                                       input rbm_pkg::rbm_mtype_t other);
      rbm_pkg::rbm_mtype_t t;
      t = other;
      case ({ras, cas})
         2'h0: t = rbm_pkg::MT_SRAM;
         2'h1: t = rbm_pkg::MT_DRAM;
         2'h2: t = rbm_pkg::MT_SDRAM;
         default: t = other;
      endcase
      return t;
   endfunction

   function automatic rbm_pkg::rbm_page_cfg_t page_types(input rbm_pkg::rbm_strap_t s,
                                                         input rbm_pkg::rbm_mtype_t fw);
      rbm_pkg::rbm_page_cfg_t c;
      if (s.boot) begin
         c.high = rbm_pkg::MT_ROM;
         c.low = strobe_type(s.ras, s.cas, rbm_pkg::MT_SRAM);
      end else begin
         c.low = rbm_pkg::MT_ROM;
         c.high = strobe_type(s.ras, s.cas, fw);
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   rbm_pkg::rbm_state_t state_reg;
   rbm_pkg::rbm_strap_t strap_reg;
   rbm_pkg::rbm_strap_t strap_pins;
   rbm_pkg::rbm_page_cfg_t cfg_reg;
   rbm_pkg::rbm_req_t cur_req_reg;
   rbm_pkg::rbm_req_t [1:0] sel_req;
   rbm_pkg::rbm_mtype_t grant_type;
   logic [rbm_pkg::CNT_W-1:0] cnt_reg;
   logic [rbm_pkg::CNT_W-1:0] step_reg;
   logic cur_unit_reg;
   logic [1:0] ack_reg;
   logic [1:0] req_v;
   logic [1:0] grant;
   logic arb_enable;
   logic capture;
   logic [1:0] loading_reg;
   logic [1:0] run_reg;
   logic [1:0] hold_valid_reg;
   logic [1:0][rbm_pkg::DATA_W-1:0] hold_data_reg;
   logic [1:0][rbm_pkg::WCNT_W-1:0] wcount_reg;

   assign strap_pins = '{boot: refresh_pin_n_i, ras: ras_pin_n_i, cas: cas_pin_n_i};
   // first edge with reset released samples the undriven straps
   assign capture = (state_reg == rbm_pkg::M_HOLD) && reset_n_i && power_down_pin_n_i;
   assign arb_enable = (state_reg == rbm_pkg::M_IDLE) && (ack_reg == 2'h0) && power_down_pin_n_i;

   ////////////////////////////////////////////////////////////////////////////
   // Request sources: bootstrap loader while loading, processor afterwards

   always_comb begin
      for (int u = 0; u < 2; u++) begin
         if (loading_reg[u]) begin
            req_v[u] = hold_valid_reg[u];
            sel_req[u].we = 1'b1;
            sel_req[u].addr = rbm_pkg::BOOT_BASE + {19'h0, wcount_reg[u]};
            sel_req[u].wdata = hold_data_reg[u];
         end else begin
            req_v[u] = run_reg[u] && cp_req_valid_i[u];
            sel_req[u] = cp_req_i[u];
         end
      end
   end

   // one shared memory space for both units
   rbm_arb u_arb (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .req_i(req_v),
      .enable_i(arb_enable),
      .grant_o(grant)
   );

   // page chosen by address bit 27
   assign grant_type = sel_req[grant[1]].addr[rbm_pkg::PAGE_BIT] ? cfg_reg.high : cfg_reg.low;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture and boot control

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         strap_reg <= '0;
         cfg_reg <= '{low: rbm_pkg::MT_ROM, high: rbm_pkg::MT_ROM};
         loading_reg <= 2'h0;
         run_reg <= 2'h0;
         synth_idle_o <= 2'h3;
         control_processor_start_o <= '0;
         processor_index_bit_o <= rbm_pkg::PROC_INDEX;
      // only the capture edge writes the straps
      end else if (capture) begin
         strap_reg <= strap_pins;
         cfg_reg <= page_types(strap_pins, fw_high_type_i);
         synth_idle_o <= 2'h3;
         if (strap_pins.boot) begin
            loading_reg <= 2'h3;
            control_processor_start_o <= {rbm_pkg::VEC_BOOT, rbm_pkg::VEC_BOOT};
         end else begin
            run_reg <= 2'h3;
            control_processor_start_o <= {rbm_pkg::VEC_ROM, rbm_pkg::VEC_ROM};
         end
      end else begin
         for (int u = 0; u < 2; u++) begin
            // jump to 0100H after the last word
            if (loading_reg[u] && (wcount_reg[u] == rbm_pkg::BOOT_WORDS)) begin
               loading_reg[u] <= 1'b0;
               run_reg[u] <= 1'b1;
               control_processor_start_o[u] <= rbm_pkg::VEC_ROM;
            end
            if (run_reg[u] && synth_start_i[u]) begin
               synth_idle_o[u] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bootstrap burst intake, one word held per unit

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         hold_valid_reg <= 2'h0;
         hold_data_reg <= '0;
         wcount_reg <= '0;
         burst_ready_o <= 2'h0;
      end else if (capture) begin
         burst_ready_o <= strap_pins.boot ? 2'h3 : 2'h0;
      end else begin
         for (int u = 0; u < 2; u++) begin
            if (burst_valid_i[u] && burst_ready_o[u]) begin
               hold_valid_reg[u] <= 1'b1;
               hold_data_reg[u] <= burst_data_i[u];
               burst_ready_o[u] <= 1'b0;
            // Ready returns only once the held word is written
            end else if (ack_reg[u] && loading_reg[u]) begin
               hold_valid_reg[u] <= 1'b0;
               wcount_reg[u] <= wcount_reg[u] + 9'h001;
               burst_ready_o[u] <= ((wcount_reg[u] + 9'h001) < rbm_pkg::BOOT_WORDS);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory cycle engine and pins

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg <= rbm_pkg::M_HOLD;
         cnt_reg <= '0;
         step_reg <= '0;
         cur_req_reg <= '0;
         cur_unit_reg <= 1'b0;
         ack_reg <= 2'h0;
         cp_rdata_o <= '0;
         sdram_init_busy_o <= 1'b0;
         osc_enable_o <= 1'b1;
         pll_enable_o <= 1'b1;
         memory_address_pins_o <= '0;
         low_page_chip_select_n_o <= 1'b1;
         high_page_chip_select_n_o <= 1'b1;
         mem_we_n_o <= 1'b1;
         mem_oe_n_o <= 1'b1;
         mem_ctrl_oe_o <= 1'b0;
         mem_data_o <= '0;
         mem_data_oe_o <= 1'b0;
         ras_pin_n_o <= 1'b1;
         cas_pin_n_o <= 1'b1;
         refresh_pin_n_o <= 1'b1;
      // float everything and stop the clocks
      end else if (!power_down_pin_n_i) begin
         state_reg <= rbm_pkg::M_OFF;
         ack_reg <= 2'h0;
         sdram_init_busy_o <= 1'b0;
         osc_enable_o <= 1'b0;
         pll_enable_o <= 1'b0;
         mem_ctrl_oe_o <= 1'b0;
         mem_data_oe_o <= 1'b0;
      end else begin
         ack_reg <= 2'h0;
         case (state_reg)
            rbm_pkg::M_HOLD: begin
               if (capture) begin
                  mem_ctrl_oe_o <= 1'b1;
                  if (strap_pins.boot) begin
                     state_reg <= rbm_pkg::M_INIT;
                     sdram_init_busy_o <= 1'b1;
                     step_reg <= '0;
                     cnt_reg <= rbm_pkg::CNT_W'(rbm_pkg::INIT_STEP_CYC - 1);
                  end else begin
                     state_reg <= rbm_pkg::M_IDLE;
                  end
               end
            end
            rbm_pkg::M_INIT: begin
               // Each step opens with a one-cycle strobe command
               ras_pin_n_o <= !(cnt_reg == rbm_pkg::CNT_W'(rbm_pkg::INIT_STEP_CYC - 1));
               cas_pin_n_o <= !(cnt_reg == rbm_pkg::CNT_W'(rbm_pkg::INIT_STEP_CYC - 1));
               refresh_pin_n_o <= !(cnt_reg == rbm_pkg::CNT_W'(rbm_pkg::INIT_STEP_CYC - 1));
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else if (step_reg == rbm_pkg::CNT_W'(rbm_pkg::INIT_STEPS - 1)) begin
                  state_reg <= rbm_pkg::M_IDLE;
                  sdram_init_busy_o <= 1'b0;
               end else begin
                  step_reg <= step_reg + 4'h1;
                  cnt_reg <= rbm_pkg::CNT_W'(rbm_pkg::INIT_STEP_CYC - 1);
               end
            end
            rbm_pkg::M_IDLE: begin
               ras_pin_n_o <= 1'b1;
               cas_pin_n_o <= 1'b1;
               refresh_pin_n_o <= 1'b1;
               if (grant != 2'h0) begin
                  cur_req_reg <= sel_req[grant[1]];
                  cur_unit_reg <= grant[1];
                  mem_we_n_o <= !sel_req[grant[1]].we;
                  mem_oe_n_o <= sel_req[grant[1]].we;
                  mem_data_o <= sel_req[grant[1]].wdata;
                  mem_data_oe_o <= sel_req[grant[1]].we;
                  if (grant_type == rbm_pkg::MT_ROM || grant_type == rbm_pkg::MT_SRAM) begin
                     state_reg <= rbm_pkg::M_STATIC;
                     cnt_reg <= rbm_pkg::CNT_W'(rbm_pkg::STATIC_CYC - 1);
                     memory_address_pins_o <= sel_req[grant[1]].addr[rbm_pkg::PIN_W-1:0];
                     low_page_chip_select_n_o <= sel_req[grant[1]].addr[rbm_pkg::PAGE_BIT];
                     high_page_chip_select_n_o <= !sel_req[grant[1]].addr[rbm_pkg::PAGE_BIT];
                  end else begin
                     state_reg <= rbm_pkg::M_ROW;
                     cnt_reg <= rbm_pkg::CNT_W'(rbm_pkg::ROW_CYC - 1);
                     memory_address_pins_o <= mux_pins(
                        sel_req[grant[1]].addr[rbm_pkg::ROW_LSB +: rbm_pkg::MUX_W]);
                     ras_pin_n_o <= 1'b0;
                  end
               end
            end
            rbm_pkg::M_STATIC: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else begin
                  state_reg <= rbm_pkg::M_IDLE;
                  cp_rdata_o <= mem_data_i;
                  ack_reg[cur_unit_reg] <= 1'b1;
                  low_page_chip_select_n_o <= 1'b1;
                  high_page_chip_select_n_o <= 1'b1;
                  mem_we_n_o <= 1'b1;
                  mem_oe_n_o <= 1'b1;
                  mem_data_oe_o <= 1'b0;
               end
            end
            rbm_pkg::M_ROW: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else begin
                  // column phase on the same pins
                  state_reg <= rbm_pkg::M_COL;
                  cnt_reg <= rbm_pkg::CNT_W'(rbm_pkg::COL_CYC - 1);
                  memory_address_pins_o <= mux_pins(cur_req_reg.addr[rbm_pkg::MUX_W-1:0]);
                  cas_pin_n_o <= 1'b0;
               end
            end
            rbm_pkg::M_COL: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else begin
                  state_reg <= rbm_pkg::M_IDLE;
                  cp_rdata_o <= mem_data_i;
                  ack_reg[cur_unit_reg] <= 1'b1;
                  ras_pin_n_o <= 1'b1;
                  cas_pin_n_o <= 1'b1;
                  mem_we_n_o <= 1'b1;
                  mem_oe_n_o <= 1'b1;
                  mem_data_oe_o <= 1'b0;
               end
            end
            // Only a reset leaves power-down
            rbm_pkg::M_OFF: begin
               state_reg <= rbm_pkg::M_OFF;
            end
            default: begin
               state_reg <= rbm_pkg::M_HOLD;
            end
         endcase
      end
   end

   assign cp_ack_o = ack_reg;
   assign control_processor_run_o = run_reg;
   assign page_cfg_o = cfg_reg;
   assign ras_pin_oe_o = mem_ctrl_oe_o;
   assign cas_pin_oe_o = mem_ctrl_oe_o;
   assign refresh_pin_oe_o = mem_ctrl_oe_o;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence seq_capture;
      capture;
   endsequence

   sequence seq_dram_cycle;
      (state_reg == rbm_pkg::M_ROW) [*2] ##1 (state_reg == rbm_pkg::M_COL) [*4]
         ##1 (state_reg == rbm_pkg::M_IDLE);
   endsequence

   index_fixed_a: assert property (processor_index_bit_o == 2'h2)
      else $error("processor index bits wrong");

   strap_sample_a: assert property (seq_capture |=> strap_reg == $past(strap_pins))
      else $error("straps not captured at release");

   strap_hold_a: assert property (state_reg != rbm_pkg::M_HOLD |=> $stable(strap_reg))
      else $error("strap configuration changed");

   init_start_a: assert property (seq_capture and strap_pins.boot |=>
      sdram_init_busy_o && state_reg == rbm_pkg::M_INIT)
      else $error("SDRAM init not started");

   synth_idle_a: assert property (seq_capture |=> synth_idle_o == 2'h3)
      else $error("engines not idle after reset");

   rom_vector_a: assert property (seq_capture and !strap_pins.boot |=>
      control_processor_start_o == {16'h0100, 16'h0100} && run_reg == 2'h3)
      else $error("stand-alone start vector wrong");

   boot_vector_a: assert property (seq_capture and strap_pins.boot |=>
      control_processor_start_o == {16'h0000, 16'h0000} && loading_reg == 2'h3)
      else $error("bootstrap start vector wrong");

   boot_range_a: assert property (grant[0] && loading_reg[0] |->
      sel_req[0].addr >= 28'h0000100 && sel_req[0].addr <= 28'h00001FF)
      else $error("bootstrap write outside load window");

   power_down_pin_float_a: assert property (!power_down_pin_n_i |=>
      !mem_ctrl_oe_o && !mem_data_oe_o && !osc_enable_o && !pll_enable_o)
      else $error("power-down did not float and stop");

   static_select_a: assert property (state_reg == rbm_pkg::M_STATIC |->
      ras_pin_n_o && cas_pin_n_o && (low_page_chip_select_n_o != high_page_chip_select_n_o)
      && (low_page_chip_select_n_o == cur_req_reg.addr[27]))
      else $error("static access select wrong");

   dram_cycle_a: assert property (disable iff (!reset_n_i || !power_down_pin_n_i)
      $rose(state_reg == rbm_pkg::M_ROW) |->
      (low_page_chip_select_n_o && high_page_chip_select_n_o) throughout seq_dram_cycle)
      else $error("DRAM cycle shape wrong");

   page_type_a: assert property (seq_capture and !strap_pins.boot |=>
      cfg_reg.low == rbm_pkg::MT_ROM)
      else $error("stand-alone low page not ROM");

endmodule // rbm_top

// ==== reset_boot_memory_config_tb.sv ====
`timescale 1ns/1ps
module reset_boot_memory_config_tb;
   logic clk_i = 1'b0, reset_n_i = 1'b0, power_down_pin_n_i = 1'b1;
   rbm_pkg::rbm_mtype_t fw_high_type_i = rbm_pkg::MT_SDRAM;
   logic [1:0] synth_start_i = 2'h0, cp_req_valid_i = 2'h0, burst_valid_i = 2'h0;
   rbm_pkg::rbm_req_t [1:0] cp_req_i = '0;
   logic [1:0][15:0] burst_data_i = '0;
   logic [1:0] cp_ack_o, burst_ready_o, control_processor_run_o, processor_index_bit_o;
   logic [1:0] synth_idle_o;
   logic [1:0][15:0] control_processor_start_o;
   rbm_pkg::rbm_page_cfg_t page_cfg_o;
   logic [15:0] cp_rdata_o, mem_data_o, mem_data_i;
   logic [26:0] memory_address_pins_o;
   logic sdram_init_busy_o, osc_enable_o, pll_enable_o, low_page_chip_select_n_o;
   logic high_page_chip_select_n_o, mem_we_n_o, mem_oe_n_o, mem_ctrl_oe_o, mem_data_oe_o;
   logic ras_pin_n_i, ras_pin_n_o, ras_pin_oe_o, cas_pin_n_i, cas_pin_n_o, cas_pin_oe_o;
   logic refresh_pin_n_i, refresh_pin_n_o, refresh_pin_oe_o;
   logic [2:0] strap = 3'h0, pins;
   int err_count = 0, checks_done = 0, cyc = 0;
   assign {refresh_pin_n_i, ras_pin_n_i, cas_pin_n_i} = pins;
   rbm_top uut (.clk_i, .reset_n_i, .power_down_pin_n_i, .fw_high_type_i, .synth_start_i,
      .cp_req_valid_i, .cp_req_i, .cp_ack_o, .cp_rdata_o, .burst_valid_i, .burst_data_i,
      .burst_ready_o, .control_processor_run_o, .control_processor_start_o,
      .processor_index_bit_o, .synth_idle_o, .page_cfg_o, .sdram_init_busy_o, .osc_enable_o,
      .pll_enable_o, .memory_address_pins_o, .low_page_chip_select_n_o,
      .high_page_chip_select_n_o, .mem_we_n_o, .mem_oe_n_o, .mem_ctrl_oe_o, .mem_data_o,
      .mem_data_oe_o, .mem_data_i, .ras_pin_n_i, .ras_pin_n_o, .ras_pin_oe_o, .cas_pin_n_i,
      .cas_pin_n_o, .cas_pin_oe_o, .refresh_pin_n_i, .refresh_pin_n_o, .refresh_pin_oe_o);
   rbm_mem_model mem (.addr_i(memory_address_pins_o),
      .cs_n_i(low_page_chip_select_n_o & high_page_chip_select_n_o), .oe_n_i(mem_oe_n_o),
      .drv_i({refresh_pin_oe_o, ras_pin_oe_o, cas_pin_oe_o}),
      .dev_i({refresh_pin_n_o, ras_pin_n_o, cas_pin_n_o}), .strap_i(strap), .pin_o(pins),
      .data_o(mem_data_i));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard well above the some 4300 cycles the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic boot(input logic [2:0] s);
      reset_n_i = 1'b0;
      strap = s;
      repeat (6) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
   endtask
   // Straps 00 01 10 map to SRAM DRAM SDRAM; 11 is firmware or SRAM
   function automatic logic [3:0] exp_cfg(input logic [2:0] s);
      logic [1:0] t;
      t = (s[1:0] == 2'h3) ? (s[2] ? 2'h1 : 2'(fw_high_type_i)) : s[1:0] + 2'h1;
      return s[2] ? {t, 2'h0} : {2'h0, t};
   endfunction
   task automatic rd(input logic [27:0] a);
      logic [2:0] seen;
      int n;
      seen = 3'h0;
      n = 0;
      cp_req_i[0] = '{we: 1'b0, addr: a, wdata: 16'h0000};
      cp_req_valid_i = 2'h1;
      while (cp_ack_o[0] !== 1'b1 && n < 30) begin
         @(negedge clk_i);
         n++;
         seen |= {!low_page_chip_select_n_o, !high_page_chip_select_n_o, !ras_pin_n_o};
      end
      cp_req_valid_i = 2'h0;
      chk("ack", 1, cp_ack_o[0]);
      chk("rdata", a[15:0] ^ 16'hA5C3, cp_rdata_o);
      chk("selects", {!a[27], a[27], 1'b0}, seen);
      @(negedge clk_i);
   endtask
   // Host streams 256 words per unit, valid held until ready takes the word
   task automatic feed();
      logic [4:0] seen;
      int n0;
      int n1;
      seen = 5'h00;
      n0 = 0;
      n1 = 0;
      while (n0 < 256 || n1 < 256) begin
         burst_valid_i = {n1 < 256, n0 < 256};
         burst_data_i = {16'(n1) ^ 16'hF000, 16'(n0)};
         if (burst_valid_i[0] && burst_ready_o[0]) n0++;
         if (burst_valid_i[1] && burst_ready_o[1]) n1++;
         @(negedge clk_i);
         seen |= {!mem_we_n_o, mem_data_oe_o, !ras_pin_n_o, !cas_pin_n_o,
            !low_page_chip_select_n_o};
      end
      burst_valid_i = 2'h0;
      repeat (30) @(negedge clk_i);
      chk("run", 2'h3, control_processor_run_o);
      chk("start", 32'h01000100, control_processor_start_o);
      chk("ready", 0, burst_ready_o);
      chk("writes", 5'h1E, seen);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int s = 0; s < 8; s++) begin
         boot(3'(s));
         chk("cfg", exp_cfg(3'(s)), page_cfg_o);
         chk("start", s[2] ? 32'h0 : 32'h01000100, control_processor_start_o);
         chk("init", s[2], sdram_init_busy_o);
         chk("index", 2'h2, processor_index_bit_o);
         chk("idle", 2'h3, synth_idle_o);
      end
      $display("test straps done");
      boot(3'h0);
      strap = 3'h7;
      rd(28'h0000234);
      rd(28'h8000456);
      chk("hold", 4'h1, page_cfg_o);
      synth_start_i = 2'h1;
      repeat (3) @(negedge clk_i);
      chk("idle", 2'h2, synth_idle_o);
      $display("test access done");
      power_down_pin_n_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk("sleep", 0, {osc_enable_o, pll_enable_o, mem_ctrl_oe_o, mem_data_oe_o});
      power_down_pin_n_i = 1'b1;
      boot(3'h0);
      chk("wake", 3, {osc_enable_o, pll_enable_o});
      $display("test power done");
      boot(3'h5);
      feed();
      chk("cfg", 4'h8, page_cfg_o);
      $display("test bootstrap done");
      end_sim();
   end
endmodule // reset_boot_memory_config_tb
